//--- verilog/stepper_ramp_generator.sv
// single-axis stepper ramp generator with step output and status flags
// assumes all inputs except rstn are synchronous to clk and held stable by the host

`timescale 1ns/1ns
`default_nettype none

module stepper_ramp_generator
    import ramp_pkg::*;
#(
    parameter int NUM_THR = 3
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // motion command
    input  wire logic [1:0]         mode,
    input  wire logic [POS_W-1:0]   target_position,
    // speeds
    input  wire logic [VEL_W-1:0]   launch_speed,
    input  wire logic [VEL_W-1:0]   halt_speed,
    input  wire logic [VEL_W-1:0]   transition_speed,
    input  wire logic [VEL_W-1:0]   peak_speed_limit,
    // accelerations
    input  wire logic [ACC_W-1:0]   first_acceleration,
    input  wire logic [ACC_W-1:0]   primary_acceleration,
    input  wire logic [ACC_W-1:0]   first_deceleration,
    input  wire logic [ACC_W-1:0]   peak_deceleration,
    // reversal pause and speed bands
    input  wire logic [PAUSE_W-1:0] reversal_pause_time,
    input  wire logic [VEL_W-1:0]   speed_threshold [NUM_THR],
    // step output
    output logic                    step_pulse,
    output logic                    move_dir,
    output logic [POS_W-1:0]        actual_position,
    output logic [VEL_W-1:0]        present_speed,
    // status
    output logic                    standstill,
    output logic                    speed_attained,
    output logic                    target_hit,
    output logic                    reversal_flag,
    output logic                    pause_active,
    output logic [NUM_THR-1:0]      speed_band_flags
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    ramp_state_t            state_r;
    logic [TICK_W-1:0]      tick_cnt_r;
    logic [PAUSE_W-1:0]     pause_cnt_r;
    logic [FRAC_W-1:0]      frac_r;
    logic [POS_W-1:0]       pos_r, dist_abs;
    logic signed [POS_W:0]  diff;
    logic [VEL_W-1:0]       vel_r, vel_nxt, step_acc_r, dv, floor_spd, start_spd;
    logic [VEL_W:0]         vel_up, floor_dv, step_sum;
    logic [2*VEL_W-1:0]     v_sq;
    logic [POS_W+ACC_W-1:0] stop_need;
    logic [ACC_W-1:0]       dec_sel, acc_sel;
    logic [ACC_W:0]         acc_sum;
    logic                   dir_r, half_r, step_r, rev_r, tick, pos_mode, vel_mode, at_target;
    logic                   goal_dir, move_req, wrong_dir, brake, slow_down, below_trans;
    logic                   go_pause, flip_now, pause_done, step_ok;

    // ---------------------------------------------------------------
    // speed update tick
    // ---------------------------------------------------------------
    // one fixed prescaler keeps every rate a pure ratio of clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
        end
    end
    assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

    // ---------------------------------------------------------------
    // motion goal
    // ---------------------------------------------------------------
    assign pos_mode  = (mode == MODE_POSITION);
    assign vel_mode  = (mode == MODE_VEL_POS) || (mode == MODE_VEL_NEG);
    assign diff      = $signed({1'b0, target_position}) - $signed({1'b0, pos_r});
    assign dist_abs  = diff[POS_W] ? POS_W'(-diff) : diff[POS_W-1:0];
    assign at_target = (diff == '0);

    always_comb begin
        goal_dir = dir_r;
        move_req = 1'b0;
        case (mode)
            MODE_POSITION: begin
                goal_dir = !diff[POS_W];
                move_req = !at_target;
            end
            MODE_VEL_POS, MODE_VEL_NEG: begin
                goal_dir = (mode == MODE_VEL_POS);
                move_req = (peak_speed_limit != '0);
            end
            default: begin
                move_req = 1'b0;
            end
        endcase
    end

    assign wrong_dir = (vel_r != '0) && move_req && (goal_dir != dir_r);

    // ---------------------------------------------------------------
    // acceleration selection and braking point
    // ---------------------------------------------------------------
    assign below_trans = (vel_r < transition_speed);
    assign dec_sel = below_trans ? first_deceleration : peak_deceleration;

    // stop distance v^2/(d*2^8) compared without a divider
    assign v_sq      = vel_r * vel_r;
    assign stop_need = dist_abs * dec_sel;
    assign brake     = ({{(POS_W + ACC_W + RAMP_SHIFT - 2*VEL_W){1'b0}}, v_sq}
                        >= {stop_need, {RAMP_SHIFT{1'b0}}});

    assign slow_down = !move_req || wrong_dir || (pos_mode && brake)
                       || (vel_r > peak_speed_limit);

    assign acc_sel = vel_mode    ? primary_acceleration
                   : slow_down   ? dec_sel
                   : below_trans ? first_acceleration : primary_acceleration;

    // per tick the speed grows or drops by acc/256, the fraction carried over
    assign acc_sum  = {1'b0, acc_sel} + {{(ACC_W + 1 - FRAC_W){1'b0}}, frac_r};
    assign dv       = {{(VEL_W - (ACC_W + 1 - FRAC_W)){1'b0}}, acc_sum[ACC_W:FRAC_W]};
    assign vel_up   = {1'b0, vel_r} + {1'b0, dv};
    assign floor_dv = {1'b0, floor_spd} + {1'b0, dv};

    assign floor_spd = (!move_req || wrong_dir) ? '0
                     : !(pos_mode && brake) ? peak_speed_limit
                     : (halt_speed < peak_speed_limit) ? halt_speed : peak_speed_limit;

    // launch of zero falls back to a plain ramp from rest
    assign start_spd = (launch_speed != '0 && launch_speed <= peak_speed_limit) ? launch_speed
                     : (launch_speed == '0 && dv <= peak_speed_limit) ? dv : peak_speed_limit;

    // ---------------------------------------------------------------
    // next speed and reversal decision
    // ---------------------------------------------------------------
    always_comb begin
        vel_nxt  = vel_r;
        go_pause = 1'b0;
        flip_now = 1'b0;
        if (tick && state_r == ST_RUN && mode != MODE_HOLD) begin
            if (vel_r == '0 && move_req && goal_dir != dir_r) begin
                if (reversal_pause_time == '0) begin
                    flip_now = 1'b1;
                end else begin
                    go_pause = 1'b1;
                end
            end else if (pos_mode && at_target) begin
                vel_nxt = '0;
            end else if (slow_down) begin
                if ({1'b0, vel_r} > floor_dv) begin
                    vel_nxt = vel_r - dv;
                end else if (vel_r > floor_spd) begin
                    vel_nxt = floor_spd;
                end
            end else if (move_req) begin
                if (vel_r == '0 && pos_mode) begin
                    vel_nxt = start_spd;
                end else if (vel_up > {1'b0, peak_speed_limit}) begin
                    vel_nxt = peak_speed_limit;
                end else begin
                    vel_nxt = vel_up[VEL_W-1:0];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // state, pause counter and direction
    // ---------------------------------------------------------------
    assign pause_done = (state_r == ST_PAUSE) && tick && (pause_cnt_r <= PAUSE_W'(1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_RUN;
            pause_cnt_r <= PAUSE_RST;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (go_pause) begin
                        state_r     <= ST_PAUSE;
                        pause_cnt_r <= reversal_pause_time;
                    end
                end
                ST_PAUSE: begin
                    if (pause_done) begin
                        state_r <= ST_RUN;
                    end else if (tick) begin
                        pause_cnt_r <= pause_cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= 1'b1;
        end else if (flip_now || pause_done) begin
            dir_r <= goal_dir;
        end
    end

    // ---------------------------------------------------------------
    // speed integrator
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vel_r  <= VEL_RST;
            frac_r <= '0;
        end else begin
            vel_r <= vel_nxt;
            if (tick) begin
                frac_r <= acc_sum[FRAC_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // step generator and position counter
    // ---------------------------------------------------------------
    // steps are held back at the target so no tick-late overshoot occurs
    assign step_ok  = (vel_r != '0) && (state_r == ST_RUN) && !(pos_mode && at_target);
    assign step_sum = {1'b0, step_acc_r} + {1'b0, vel_r};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_r     <= 1'b0;
            step_acc_r <= '0;
            step_r     <= 1'b0;
        end else begin
            half_r <= !half_r;
            step_r <= 1'b0;
            if (half_r && step_ok) begin
                step_acc_r <= step_sum[VEL_W-1:0];
                step_r     <= step_sum[VEL_W];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= POS_RST;
        end else if (half_r && step_ok && step_sum[VEL_W]) begin
            pos_r <= dir_r ? pos_r + 1'b1 : pos_r - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // reversal flag
    // ---------------------------------------------------------------
    // a fresh reversal outranks the clear from a target hit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rev_r <= 1'b0;
        end else if (pos_mode && tick && state_r == ST_RUN && wrong_dir) begin
            rev_r <= 1'b1;
        end else if (target_hit) begin
            rev_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign step_pulse      = step_r;
    assign move_dir        = dir_r;
    assign actual_position = pos_r;
    assign present_speed   = vel_r;
    assign standstill      = (vel_r == '0);
    assign speed_attained  = (vel_r == peak_speed_limit);
    assign target_hit      = pos_mode && at_target && (vel_r == '0);
    assign reversal_flag   = rev_r;
    assign pause_active    = (state_r == ST_PAUSE);

    speed_band #(
        .NUM_THR (NUM_THR)
    ) u_band (
        .clk             (clk),
        .rst_n           (rst_n),
        .present_speed   (vel_r),
        .speed_threshold (speed_threshold),
        .above_r         (speed_band_flags)
    );

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    step_up_a: assert property (step_pulse && $past(dir_r) |->
        actual_position == $past(actual_position) + 1'b1)
        else $error("forward step did not count position up");
    step_down_a: assert property (step_pulse && !$past(dir_r) |->
        actual_position == $past(actual_position) - 1'b1)
        else $error("reverse step did not count position down");
    rest_no_step_a: assert property (standstill |=> !step_pulse)
        else $error("step issued from standstill");
    vel_zero_brake_a: assert property (tick && vel_mode && peak_speed_limit == '0
        && vel_r != '0 && primary_acceleration >= 16'h0100 && state_r == ST_RUN
        |=> vel_r < $past(vel_r))
        else $error("zero peak speed did not brake");
    pause_still_a: assert property (pause_active |-> standstill && !step_pulse)
        else $error("motion during reversal pause");
    pause_span_a: assert property ($rose(pause_active) && reversal_pause_time != '0
        |-> pause_active [*8])
        else $error("reversal pause ended early");
    hit_no_step_a: assert property (target_hit |=> !step_pulse)
        else $error("step issued at target");
    launch_jump_a: assert property (pos_mode && $past(pos_mode) && $past(vel_r) == '0
        && vel_r != '0 && launch_speed != '0 && launch_speed <= peak_speed_limit
        && $stable(launch_speed) |-> vel_r == launch_speed)
        else $error("position move did not start at launch speed");
    reach_hold_a: assert property (tick && vel_mode && speed_attained
        && $stable(peak_speed_limit) && mode == $past(mode) |=> speed_attained)
        else $error("attained speed not held");
    rev_cause_a: assert property ($rose(reversal_flag) |-> $past(vel_r) != '0)
        else $error("reversal flagged without motion");
    reversal_c: cover property ($rose(reversal_flag));
    pause_c: cover property ($fell(pause_active));
    target_c: cover property ($rose(target_hit));
    attain_c: cover property (vel_mode && $rose(speed_attained) && !standstill);
endmodule // stepper_ramp_generator

`default_nettype wire

//--- include/ramp_pkg.sv
// ramp generator constants, widths and enumerations
// assumes a single 100 MHz clock shared by every block that imports it

package ramp_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int VEL_W   = 23;
    localparam int POS_W   = 32;
    localparam int ACC_W   = 16;
    localparam int PAUSE_W = 16;
    localparam int FRAC_W  = 8;

    // ---------------------------------------------------------------
    // timing and scaling
    // ---------------------------------------------------------------
    // 512 cycles per speed update, 2^8 fractional acc bits: 512*256
    localparam int TICK_CYCLES = 512;
    localparam int TICK_W      = 9;
    // coarse compare drops this many low bits of each speed value
    localparam int CMP_IGNORE  = 8;
    // brake compare shift of the ramp-length relation
    localparam int RAMP_SHIFT  = 8;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [POS_W-1:0]   POS_RST   = 32'h0000_0000;
    localparam logic [VEL_W-1:0]   VEL_RST   = 23'h00_0000;
    localparam logic [PAUSE_W-1:0] PAUSE_RST = 16'h0000;

    // ---------------------------------------------------------------
    // enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_POSITION = 2'b00,
        MODE_VEL_POS  = 2'b01,
        MODE_VEL_NEG  = 2'b10,
        MODE_HOLD     = 2'b11
    } motion_mode_t;

    typedef enum logic {
        ST_RUN   = 1'b0,
        ST_PAUSE = 1'b1
    } ramp_state_t;

endpackage

//--- verilog/speed_band.sv
// velocity threshold comparators, one flag per threshold
// assumes present_speed comes from a flip-flop in the same clock domain

`timescale 1ns/1ns
`default_nettype none

module speed_band
    import ramp_pkg::*;
#(
    parameter int NUM_THR = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // speed and limits
    input  wire logic [VEL_W-1:0] present_speed,
    input  wire logic [VEL_W-1:0] speed_threshold [NUM_THR],
    // one bit per limit, set when the speed's upper bits are at or above the limit's
    output logic [NUM_THR-1:0]    above_r
);

    // upper bits only: the fine detail is not worth the comparator area
    function automatic logic [VEL_W-CMP_IGNORE-1:0] coarse(input logic [VEL_W-1:0] v);
        return v[VEL_W-1:CMP_IGNORE];
    endfunction

    genvar i;
    generate
        for (i = 0; i < NUM_THR; i++) begin : g_thr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    above_r[i] <= 1'b0;
                end else begin
                    above_r[i] <= coarse(present_speed) >= coarse(speed_threshold[i]);
                end
            end

            // the first edge out of reset still sees the reset value of the flag
            band_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
                $past(rst_n) |-> above_r[i] == ($past(present_speed[VEL_W-1:CMP_IGNORE])
                               >= $past(speed_threshold[i][VEL_W-1:CMP_IGNORE])))
                else $error("speed band flag disagrees with coarse compare");
        end
    endgenerate

endmodule // speed_band

`default_nettype wire

//--- dv/ramp_host.sv
// host model: holds the ramp parameters that the controller writes
// assumes the bench calls its task just after a falling clock edge

`timescale 1ns/1ns
`default_nettype none

module ramp_host
    import ramp_pkg::*;
#(
    parameter int NUM_THR = 3
) (
    // command and speeds
    output var logic [1:0]         mode,
    output var logic [POS_W-1:0]   target_position,
    output var logic [VEL_W-1:0]   launch_speed,
    output var logic [VEL_W-1:0]   halt_speed,
    output var logic [VEL_W-1:0]   transition_speed,
    output var logic [VEL_W-1:0]   peak_speed_limit,
    // accelerations, pause and bands
    output var logic [ACC_W-1:0]   accel_set [4],
    output var logic [PAUSE_W-1:0] reversal_pause_time,
    output var logic [VEL_W-1:0]   speed_threshold [NUM_THR]
);
    // ---------------------------------------------------------------
    // parameter writes
    // ---------------------------------------------------------------
    initial begin
        mode                = 2'h0;
        target_position     = 32'h0000_0000;
        launch_speed        = 23'h00_0000;
        halt_speed          = 23'h00_0001;
        transition_speed    = 23'h08_0000;
        peak_speed_limit    = 23'h00_0000;
        accel_set           = '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
        reversal_pause_time = 16'h0002;
        // low byte differs on purpose: only the upper bits may count
        speed_threshold     = '{23'h00_04ff, 23'h00_0500, 23'h00_0000};
    end

    task automatic program_move(input logic [1:0] m, input logic [POS_W-1:0] t,
                                input logic [VEL_W-1:0] ls, input logic [VEL_W-1:0] pk);
        mode             = m;
        target_position  = t;
        launch_speed     = ls;
        halt_speed       = (ls == 23'h00_0000) ? 23'h00_0001 : ls;
        peak_speed_limit = pk;
    endtask
endmodule // ramp_host

`default_nettype wire

//--- dv/stepper_ramp_generator_tb.sv
// self-checking bench for the ramp generator: position move, reversal, velocity mode
// assumes ramp_pkg and the host model are compiled first

`timescale 1ns/1ns
`default_nettype none

module stepper_ramp_generator_tb;
    import ramp_pkg::*;
    logic clk, rstn;
    logic [1:0] mode;
    logic [POS_W-1:0] target_position, actual_position;
    logic [VEL_W-1:0] launch_speed, halt_speed, transition_speed, peak_speed_limit, present_speed;
    logic [ACC_W-1:0] accel_set [4];
    logic [PAUSE_W-1:0] reversal_pause_time;
    logic [VEL_W-1:0] speed_threshold [3];
    logic step_pulse, move_dir, standstill, speed_attained, target_hit, reversal_flag, pause_active;
    logic [2:0] speed_band_flags;
    int n_mismatch, n_checks, n_steps, c0;

    // ---------------------------------------------------------------
    // clock, reset, instances
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ramp_host host (.mode, .target_position, .launch_speed, .halt_speed, .transition_speed,
                    .peak_speed_limit, .accel_set, .reversal_pause_time, .speed_threshold);
    stepper_ramp_generator uut (.clk, .rstn, .mode, .target_position, .launch_speed, .halt_speed,
        .transition_speed, .peak_speed_limit, .first_acceleration(accel_set[0]),
        .primary_acceleration(accel_set[1]), .first_deceleration(accel_set[2]),
        .peak_deceleration(accel_set[3]), .reversal_pause_time, .speed_threshold, .step_pulse,
        .move_dir, .actual_position, .present_speed, .standstill, .speed_attained, .target_hit,
        .reversal_flag, .pause_active, .speed_band_flags);
    always @(posedge clk) if (step_pulse === 1'b1) n_steps <= n_steps + 1;

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic bit cond(input int k);
        case (k)
            0: return standstill === 1'b0;
            1: return standstill === 1'b1;
            2: return speed_attained === 1'b1;
            3: return target_hit === 1'b1;
            4: return pause_active === 1'b1;
            default: return reversal_flag === 1'b1;
        endcase
    endfunction

    // bounded wait, ends just after a falling edge
    task automatic wait_for(input int k, input int lim);
        int i;
        for (i = 0; i < lim && !cond(k); i++) @(negedge clk);
        check("wait condition", {31'h0, cond(k)}, 32'h1);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        check("standstill", standstill, 1);
        check("target hit at zero", target_hit, 1);
        check("position", actual_position, 0);
        check("pause", pause_active, 0);
    endtask

    task automatic t_position;
        host.program_move(2'h0, 32'd100, 23'h10_0000, 23'h10_0000);
        @(negedge clk);
        check("target hit left", target_hit, 0);
        wait_for(0, 700);
        check("launch speed", present_speed, 32'h10_0000);
        c0 = n_steps;
        // 20 step periods plus half of one: the accumulator phase at launch is free
        repeat (328) @(negedge clk);
        check("step rate", n_steps - c0, 20);
        wait_for(3, 3000);
        check("position at target", actual_position, 100);
        check("step count", n_steps, 100);
        check("standstill at end", standstill, 1);
    endtask

    task automatic t_reversal;
        host.program_move(2'h0, 32'd200, 23'h00_0800, 23'h00_0800);
        wait_for(0, 700);
        host.program_move(2'h0, 32'd50, 23'h00_0800, 23'h00_0800);
        wait_for(5, 1100);
        wait_for(4, 8000);
        c0 = 0;
        while (pause_active === 1'b1 && c0 < 3000) begin
            check("no step in pause", step_pulse, 0);
            @(negedge clk);
            c0++;
        end
        check("pause length", c0, 2 * TICK_CYCLES);
        host.program_move(2'h0, 32'd50, 23'h10_0000, 23'h10_0000);
        wait_for(3, 4000);
        check("direction back", move_dir, 0);
        check("position back", actual_position, 50);
        // the flag drops on the edge after target hit
        @(negedge clk);
        check("reversal cleared", reversal_flag, 0);
    endtask

    task automatic t_velocity;
        host.program_move(2'h1, 32'd0, 23'h00_0000, 23'h00_0400);
        wait_for(2, 5000);
        check("velocity speed", present_speed, 32'h400);
        check("velocity dir", move_dir, 1);
        @(negedge clk);
        check("speed bands", speed_band_flags, 3'b101);
        host.program_move(2'h1, 32'd0, 23'h00_0000, 23'h00_0000);
        wait_for(1, 3500);
        check("stopped speed", present_speed, 0);
        check("attained at zero", speed_attained, 1);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        n_checks   = 0;
        n_steps    = 0;
        rstn       = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_position();
        t_reversal();
        t_velocity();
        report_and_stop();
    end

    initial begin
        #600000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // stepper_ramp_generator_tb

`default_nettype wire
